// *** hdl/cfo_consts.svh ***
// offsets, field positions, reset values and timing counts of the clock fanout control
`ifndef CFO_CONSTS_SVH
`define CFO_CONSTS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define CFO_ADDR_ENABLE 12'h000
`define CFO_ADDR_STATUS 12'h004
`define CFO_ADDR_W 12
// ----------------------------------------
// reset values and field positions
// ----------------------------------------
`define CFO_ENABLE_RESET 8'hFF
`define CFO_STAT_RUN_LSB 0
`define CFO_STAT_STATE_LSB 8
`define CFO_STAT_FREQ_BIT 12
`define CFO_STAT_ADDR_BIT 13
`define CFO_STAT_MODE_LSB 14
`define CFO_STAT_PD_BIT 16
// ----------------------------------------
// timing
// ----------------------------------------
`define CFO_CLK_PERIOD_NS 10
`define CFO_STARTUP_DELAY_NS 100000
`define CFO_STARTUP_CYCLES ((`CFO_STARTUP_DELAY_NS + `CFO_CLK_PERIOD_NS - 1) / `CFO_CLK_PERIOD_NS)
`define CFO_PD_EDGES 2'h2
// ----------------------------------------
// three-level mode pin codes
// ----------------------------------------
`define CFO_LVL_HIGH 2'h3
`define CFO_LVL_MID 2'h1
`define CFO_LVL_LOW 2'h0
`endif

// *** hdl/cfo_pkg.sv ***
// types of the clock fanout control
package cfo_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_DELAY = 4'b0001,
    ST_READY = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DOWN = 4'b1000
  } cfo_state_t;

  // loop mode chosen by the three-level pin
  typedef enum logic [1:0] {
    MODE_LOW_BW = 2'h0,
    MODE_BYPASS = 2'h1,
    MODE_HIGH_BW = 2'h2
  } cfo_mode_t;

  // configuration captured at first power-good
  typedef struct packed {
    logic freqSel100;
    logic busAddrSel;
    cfo_mode_t loopMode;
  } cfo_cfg_t;
endpackage

// *** hdl/cfo_fanout_ctrl.sv ***
// output gating, power-good/power-down sequencing and apb registers of an 8-pair fanout buffer
// Function
// R1 - pair runs when pin low and bit set
// R2 - software enable bits high, reset enabled
// R3 - disabled pair drives both legs low
// R4 - enable pins resynchronised before use
// R5 - output start without runt pulse
// R6 - output stop without runt pulse
// R7 - frequency select pin picks 100/133 MHz
// R8 - power pin low tri-states, high runs
// R9 - first power-good captures configuration straps
// R10 - later, pin low requests clean power-down
// R11 - two low comp rises, off at fall
// R12 - controller drops request before stopping clock
// R13 - stopping reference before request is undefined
// R14 - mode pin: high bw, bypass, low bw
// R15 - wait startup delay after supply valid
// R16 - outputs off until power, clock, lock
// R17 - high=high bw, mid=bypass, low=low bw
// R18 - parameter selects disabled output level
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "cfo_consts.svh"

module cfo_fanout_ctrl #(
  parameter int NUM_OUT = 8,
  parameter int STARTUP_CYCLES = `CFO_STARTUP_CYCLES,
  parameter bit DISABLE_HIZ = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // asynchronous pins
  input wire logic [NUM_OUT-1:0] oe_n,
  input wire logic power_good_down_pin,
  input wire logic freq_sel_pin,
  input wire logic bus_addr_select,
  input wire logic [1:0] mode_level,
  input wire logic clk_valid,
  input wire logic pll_locked,
  // differential outputs
  output logic [NUM_OUT-1:0] diff_out_true,
  output logic [NUM_OUT-1:0] diff_out_comp,
  output logic [NUM_OUT-1:0] diff_out_oe,
  // captured configuration and state
  output cfo_pkg::cfo_cfg_t cfg,
  output logic powered_down
);

  localparam int SW = NUM_OUT + 7;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] syncA;
  logic [SW-1:0] syncB;
  wire logic [SW-1:0] rawPins = {oe_n, power_good_down_pin, freq_sel_pin, bus_addr_select, mode_level,
                                 clk_valid, pll_locked};

  // R4 two-stage resync
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      syncA <= '0;
      syncB <= '0;
    end else begin
      syncA <= rawPins;
      syncB <= syncA;
    end
  end

  // named synchronised levels
  wire logic [NUM_OUT-1:0] oeNSync = syncB[SW-1:7];
  wire logic pwrPin = syncB[6];
  wire logic freqSync = syncB[5];
  wire logic addrSync = syncB[4];
  wire logic [1:0] modeSync = syncB[3:2];
  wire logic clkOk = syncB[1];
  wire logic lockOk = syncB[0];

  // ----------------------------------------
  // mode decode and configuration capture
  // ----------------------------------------
  // R17 three-level decode
  wire cfo_pkg::cfo_mode_t decMode = (modeSync == `CFO_LVL_HIGH) ? cfo_pkg::MODE_HIGH_BW :
                                     (modeSync == `CFO_LVL_LOW) ? cfo_pkg::MODE_LOW_BW : cfo_pkg::MODE_BYPASS;
  wire cfo_pkg::cfo_cfg_t sampledCfg = '{freqSel100: freqSync, busAddrSel: addrSync, loopMode: decMode};

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  cfo_pkg::cfo_state_t state;
  cfo_pkg::cfo_state_t next_state;
  logic [31:0] delayCnt;
  logic cfgTaken;
  logic allOn;
  logic phase;
  logic [1:0] pdCount;

  wire logic delayDone = (delayCnt >= 32'(STARTUP_CYCLES - 1));
  // R16 bypass needs no lock
  wire logic lockReady = lockOk || (cfg.loopMode == cfo_pkg::MODE_BYPASS && cfgTaken) ||
                         (!cfgTaken && decMode == cfo_pkg::MODE_BYPASS);
  wire logic readyGo = pwrPin && clkOk && lockReady;
  // comp leg rises at this edge when phase is high, falls when low
  wire logic compRise = phase;
  wire logic compFall = !phase;
  wire logic pdArmed = (pdCount == `CFO_PD_EDGES);

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      cfo_pkg::ST_DELAY: begin
        if (delayDone) begin
          next_state = cfo_pkg::ST_READY;
        end
      end
      cfo_pkg::ST_READY: begin
        if (readyGo) begin
          next_state = cfo_pkg::ST_RUN;
        end
      end
      cfo_pkg::ST_RUN: begin
        if (pdArmed && compFall) begin
          next_state = cfo_pkg::ST_DOWN;
        end
      end
      cfo_pkg::ST_DOWN: begin
        if (pwrPin) begin
          next_state = cfo_pkg::ST_READY;
        end
      end
    endcase
  end

  // R15 startup delay counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      delayCnt <= '0;
    end else if (state == cfo_pkg::ST_DELAY && !delayDone) begin
      delayCnt <= delayCnt + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state <= cfo_pkg::ST_DELAY;
    end else begin
      state <= next_state;
    end
  end

  // R9 R7 R14 capture straps on first assertion only
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfgTaken <= 1'b0;
      cfg <= '0;
    end else if (!cfgTaken && state == cfo_pkg::ST_READY && readyGo) begin
      cfgTaken <= 1'b1;
      cfg <= sampledCfg;
    end
  end

  // R11 count consecutive comp rises with request low
  always_ff @(posedge ref_clk) begin
    if (!reset_n || state != cfo_pkg::ST_RUN) begin
      pdCount <= '0;
    end else if (compRise) begin
      if (pwrPin) begin
        pdCount <= '0;
      end else if (!pdArmed) begin
        pdCount <= pdCount + 2'h1;
      end
    end
  end

  // R8 R10 R16 global output on flag
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      allOn <= 1'b0;
    end else begin
      allOn <= (next_state == cfo_pkg::ST_RUN);
    end
  end

  // output phase toggles each edge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  logic [NUM_OUT-1:0] swEnable;
  wire logic [`CFO_ADDR_W-1:0] regAddr = paddr[`CFO_ADDR_W-1:0];
  wire logic hitEnable = (regAddr == `CFO_ADDR_ENABLE);
  wire logic hitStatus = (regAddr == `CFO_ADDR_STATUS);
  wire logic accessDone = psel && penable && pready;
  wire logic swWrite = accessDone && pwrite && hitEnable;
  logic [NUM_OUT-1:0] gate;
  wire logic [31:0] statusWord = 32'(gate) | (32'(state) << `CFO_STAT_STATE_LSB) |
                                 (32'(cfg.freqSel100) << `CFO_STAT_FREQ_BIT) |
                                 (32'(cfg.busAddrSel) << `CFO_STAT_ADDR_BIT) |
                                 (32'(cfg.loopMode) << `CFO_STAT_MODE_LSB) |
                                 (32'(state == cfo_pkg::ST_DOWN) << `CFO_STAT_PD_BIT);
  wire logic [31:0] readWord = hitEnable ? 32'(swEnable) : hitStatus ? statusWord : 32'h0000_0000;

  // R2 enable bits reset to enabled
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      swEnable <= NUM_OUT'(`CFO_ENABLE_RESET);
    end else if (swWrite) begin
      swEnable <= pwdata[NUM_OUT-1:0];
    end
  end

  // one wait state, then ready with data
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      prdata <= readWord;
      pslverr <= psel && penable && !pready && !hitEnable && !hitStatus;
    end
  end

  // ----------------------------------------
  // per-pair gating and drivers
  // ----------------------------------------
  // R1 pin low and bit set
  wire logic [NUM_OUT-1:0] want = ~oeNSync & swEnable & {NUM_OUT{allOn}};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUT; gi = gi + 1) begin : g_pair
      // R5 R6 change only as true leg falls
      wire logic next_gate = (phase || !allOn) ? want[gi] : gate[gi];
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          gate[gi] <= 1'b0;
          diff_out_true[gi] <= 1'b0;
          diff_out_comp[gi] <= 1'b0;
          diff_out_oe[gi] <= 1'b0;
        end else begin
          // R3 disabled pair low on both legs
          diff_out_true[gi] <= next_gate && !phase;
          diff_out_comp[gi] <= next_gate && phase;
          gate[gi] <= next_gate;
          // R18 disabled level low/low or hi-z
          diff_out_oe[gi] <= (next_state == cfo_pkg::ST_RUN) && (next_gate || !DISABLE_HIZ);
        end
      end
    end
  endgenerate

  // power-down indicator
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      powered_down <= 1'b0;
    end else begin
      powered_down <= (next_state == cfo_pkg::ST_DOWN);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_enable_reset: assert property (@(posedge ref_clk) $past(!reset_n) && reset_n |-> swEnable == 8'hFF) // R2
    else $error("enable bits not set after reset");
  chk_pin_gates: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(gate[0]) |-> $past(!oeNSync[0] && swEnable[0])) // R1
    else $error("pair started without pin and bit");
  chk_off_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !gate[0] |-> !diff_out_true[0] && !diff_out_comp[0]) // R3
    else $error("disabled pair toggles");
  chk_start_clean: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(gate[0]) |-> !diff_out_true[0] && diff_out_comp[0]) // R5
    else $error("start not on full phase");
  chk_stop_clean: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(gate[0]) && $past(allOn) |-> $past(diff_out_true[0])) // R6
    else $error("stop cut a high pulse");
  chk_pd_edges: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(powered_down) |-> $past(pdCount) == 2'h2 && $past(!phase)) // R11
    else $error("power-down without two low edges");
  chk_pd_tristate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    powered_down |-> diff_out_oe == '0) // R8
    else $error("outputs driven while powered down");
  chk_cfg_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(cfgTaken) |-> $stable(cfg)) // R9
    else $error("configuration changed after capture");
  chk_startup_wait: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(state) == cfo_pkg::ST_DELAY && state != cfo_pkg::ST_DELAY |-> $past(delayCnt) == 32'(STARTUP_CYCLES - 1)) // R15
    else $error("startup delay cut short");
  chk_run_needs: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(allOn) |-> $past(pwrPin && clkOk && lockReady)) // R16
    else $error("outputs on without power and clock");
  chk_mode_decode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    modeSync == 2'h3 |-> decMode == cfo_pkg::MODE_HIGH_BW) // R17
    else $error("high level not decoded as high bandwidth");
  chk_apb_ready: assert property (@(posedge ref_clk) disable iff (!reset_n)
    psel && penable && !pready |=> pready) // apb wait state
    else $error("apb answer late");
  // pin resync, gate phase, capture, power-down, outputs off outside run and disabled level
  chk_sync_delay: assert property (@(posedge ref_clk) disable iff (!reset_n) // R4
    $past(reset_n) && $past(reset_n, 2) |-> oeNSync == $past(oe_n, 2))
    else $error("enable pins not two flops late");
  chk_gate_phase: assert property (@(posedge ref_clk) disable iff (!reset_n) // R5
    $changed(gate[0]) && $past(allOn) |-> $past(phase))
    else $error("pair gate changed mid period");
  chk_freq_capture: assert property (@(posedge ref_clk) disable iff (!reset_n) // R7
    $rose(cfgTaken) |-> cfg.freqSel100 == $past(freqSync))
    else $error("frequency strap not captured");
  chk_pd_stays: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
    powered_down && !pwrPin |=> powered_down)
    else $error("left power-down while request low");
  chk_pd_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
    state == cfo_pkg::ST_RUN && compRise && pwrPin |=> pdCount == 2'h0)
    else $error("edge count kept after request high");
  chk_off_all: assert property (@(posedge ref_clk) disable iff (!reset_n) // R16
    !allOn |-> diff_out_oe == '0)
    else $error("pairs driven outside run");
  chk_hiz_level: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
    allOn && !gate[0] |-> diff_out_oe[0] == !DISABLE_HIZ)
    else $error("disabled pair level not as chosen");

endmodule

// *** tb/cfo_clk_partner.sv ***
// upstream clock source and loop lock model for the fanout control bench
`timescale 1ns/10ps
module cfo_clk_partner (
  // clock and controls
  input wire logic ref_clk,
  input wire logic srcOn,
  input wire logic [3:0] lockDelay,
  // status levels
  output logic clkValid,
  output logic pllLocked
);
  logic [3:0] lockCnt;
  // clock stays valid while on, lock follows after a chosen delay
  // clock valid and lock drop the edge after srcOn goes low, in any state of the fanout control
  always_ff @(posedge ref_clk) begin
    clkValid <= srcOn;
    if (!srcOn) begin
      lockCnt <= 4'h0;
      pllLocked <= 1'b0;
    end else if (lockCnt != lockDelay) begin
      lockCnt <= lockCnt + 4'h1;
    end else begin
      pllLocked <= 1'b1;
    end
  end
endmodule

// *** tb/clock_fanout_output_control_bench.sv ***
// self-checking bench of the clock fanout control
`timescale 1ns/10ps
`include "cfo_consts.svh"
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin nFail++; $display("[ERR] %0t value mismatch", $time); end end
module clock_fanout_output_control_bench;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, err, pin = 0, freq = 1, addrSel = 0, srcOn = 0, powered_down;
  logic [7:0] oe_n = 0, dT, dC, dOe, pT = 0, pC = 0, sw;
  logic [1:0] lvl = 0;
  logic clkValid, pllLocked;
  logic [3:0] lockDelay = 4'h3;
  cfo_pkg::cfo_cfg_t cfg;
  int nFail = 0, checkCount = 0, cyc = 0;
  // ----------------------------------------
  // clock, design, partner
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;
  cfo_fanout_ctrl #(.STARTUP_CYCLES(8)) u_cfo_fanout_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oe_n(oe_n), .power_good_down_pin(pin), .freq_sel_pin(freq), .bus_addr_select(addrSel),
    .mode_level(lvl), .clk_valid(clkValid), .pll_locked(pllLocked), .diff_out_true(dT), .diff_out_comp(dC),
    .diff_out_oe(dOe), .cfg(cfg), .powered_down(powered_down));
  cfo_clk_partner u_cfo_clk_partner (.ref_clk(ref_clk), .srcOn(srcOn), .lockDelay(lockDelay),
    .clkValid(clkValid), .pllLocked(pllLocked));
  // edge monitor: start with comp high, stop right after true high
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 6000) begin
      nFail++;
      report_and_stop();
    end
    for (int i = 0; i < 8; i++) begin
      if (reset_n && !(pT[i] | pC[i]) && (dT[i] | dC[i])) `CHK(dC[i], 1'b1)
      if (reset_n && (pT[i] | pC[i]) && !(dT[i] | dC[i]) && !powered_down) `CHK(pT[i], 1'b1)
    end
    pT <= dT;
    pC <= dC;
  end
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic waitRun();
    do @(posedge ref_clk); while (dOe !== 8'hff);
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic boot(input logic [1:0] l, input logic f, input logic s);
    @(posedge ref_clk);
    reset_n <= 0;
    pin <= 0;
    lvl <= l;
    freq <= f;
    addrSel <= s;
    lockDelay <= 4'($urandom_range(15));
    // reference stops only after the request is low
    repeat (2) @(posedge ref_clk);
    srcOn <= 0;
    repeat (2) @(posedge ref_clk);
    srcOn <= 1;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1;
    repeat (3) @(posedge ref_clk);
    `CHK(dOe, 8'h00)
    pin <= 1;
    waitRun();
  endtask
  function automatic cfo_pkg::cfo_mode_t expMode(input logic [1:0] l);
    return (l == `CFO_LVL_HIGH) ? cfo_pkg::MODE_HIGH_BW : (l == `CFO_LVL_LOW) ? cfo_pkg::MODE_LOW_BW : cfo_pkg::MODE_BYPASS;
  endfunction
  task automatic report_and_stop();
    $display("tests done: %0d checks, %0d mismatches", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'he32e0873));
    // every mode level and both straps captured at power-good
    for (int k = 0; k < 4; k++) begin
      boot(2'(k), k[0], k[1]);
      `CHK(cfg.loopMode, expMode(2'(k)))
      `CHK(cfg.freqSel100, k[0])
      `CHK(cfg.busAddrSel, k[1])
      apb(0, `CFO_ADDR_STATUS, 0);
      `CHK(rd[15:14], expMode(2'(k)))
      $display("boot test %0d done", k);
    end
    apb(0, `CFO_ADDR_ENABLE, 0);
    `CHK(rd, 32'h0000_00ff)
    apb(0, 32'h0000_0010, 0);
    `CHK(err, 1'b1)
    // random gating of the pairs by bits and pins
    for (int k = 0; k < 8; k++) begin
      sw = (k == 0) ? 8'h00 : 8'($urandom);
      apb(1, `CFO_ADDR_ENABLE, {24'h0, sw});
      oe_n <= (k == 1) ? 8'hff : 8'($urandom);
      repeat (8) @(posedge ref_clk);
      apb(0, `CFO_ADDR_STATUS, 0);
      `CHK(rd[7:0], sw & ~oe_n)
      `CHK(dT & ~(sw & ~oe_n), 8'h00)
      `CHK(dC & ~(sw & ~oe_n), 8'h00)
      `CHK((dT ^ dC) & (sw & ~oe_n), sw & ~oe_n)
    end
    $display("gating test done");
    // power-down and return without recapture
    pin <= 0;
    freq <= ~cfg.freqSel100;
    repeat (12) @(posedge ref_clk);
    `CHK(powered_down, 1'b1)
    `CHK(dOe, 8'h00)
    `CHK(dT | dC, 8'h00)
    pin <= 1;
    oe_n <= 8'h00;
    waitRun();
    `CHK(cfg.freqSel100, ~freq)
    `CHK(powered_down, 1'b0)
    $display("power test done");
    report_and_stop();
  end
endmodule
